// ---- hdl/fpc_pkg.sv ----
// Shared constants, types and decode functions for the front-panel control block.
package fpc_pkg;

	// Clock rate and time figures, each with its derived cycle count.
	localparam int CLK_HZ = 10_000_000;
	localparam int BLINK_S = 15;
	localparam int BLINK_CYC = BLINK_S * CLK_HZ;
	localparam int FLASH_MS = 250;
	localparam int FLASH_CYC = FLASH_MS * (CLK_HZ / 1000);
	localparam int DEB_MS = 5;
	localparam int DEB_CYC = DEB_MS * (CLK_HZ / 1000);

	// Bit positions of the button and status pin groups.
	localparam int BTN_MODE = 0;
	localparam int BTN_RIGHT = 1;
	localparam int BTN_LEFT = 2;
	localparam int NBTN = 3;
	localparam int STS_PWR = 0;
	localparam int STS_REFV = 1;
	localparam int STS_REFL = 2;
	localparam int NSTS = 3;

	// Parameter indices; presets sit above the panel sections.
	localparam logic [3:0] P_GRP = 4'h0;
	localparam logic [3:0] P_VAR = 4'h1;
	localparam logic [3:0] P_AUD = 4'h2;
	localparam logic [3:0] P_SLT = 4'h3;
	localparam logic [3:0] P_STD = 4'h4;
	localparam logic [3:0] P_MOD = 4'h5;
	localparam logic [3:0] P_HDF = 4'h6;
	localparam logic [3:0] P_AUX1 = 4'h7;
	localparam logic [3:0] P_REF = 4'hA;
	localparam logic [3:0] P_PRE1 = 4'hB;
	localparam int NPAR = 14;
	localparam int NSEC = 3;
	localparam int NAUX = 3;
	localparam int NPRE = 3;
	localparam int NGRP = 7;
	localparam int NHDF = 4;
	localparam logic [3:0] PAR_RST = 4'h0;

	// Pattern groups and their variant limits.
	localparam logic [3:0] GRP_BLACK = 4'h0;
	localparam logic [3:0] GRP_BARS = 4'h1;
	localparam logic [3:0] GRP_PRE1 = 4'h4;
	localparam logic [3:0] GRP_MAX = 4'h6;
	localparam logic [3:0] VAR_BLACK_MAX = 4'h2;
	localparam logic [3:0] VAR_BARS_MAX = 4'h5;
	localparam logic [3:0] PRESET_MAX = 4'hE;

	// Aux sources: 0 linear_timecode, 1..8 AES pairs, 9 silence, 10 word clock, 11 6 Hz.
	localparam logic [3:0] AUX_LTC = 4'h0;
	localparam logic [3:0] AUX_AES1 = 4'h1;
	localparam logic [3:0] AUX_SILENCE = 4'h9;
	localparam logic [3:0] AUX_WCLK = 4'hA;
	localparam logic [3:0] AUX_PULSE6 = 4'hB;

	// Reference types: 525, 625, 10 MHz clock, tri_level_sync; HD formats in lamp order.
	localparam logic [3:0] REF_MAX = 4'h3;
	localparam logic [3:0] HDF_MAX = 4'h3;
	localparam logic [3:0] BIN_MAX = 4'h1;

	typedef struct packed {
		logic [3:0] idx;
		logic [3:0] val;
	} fpc_wr_t;

	typedef struct packed {
		logic [3:0] grp;
		logic [3:0] variant;
		logic [3:0] preset;
	} fpc_pat_t;

	typedef enum logic [1:0] {ST_IDLE, ST_BROWSE, ST_VALUE} fpc_state_t;

	// Highest legal value of a parameter, given the current pattern group.
	function automatic logic [3:0] parMax(input logic [3:0] idx, input logic [3:0] grp);
		if (idx == P_GRP) return GRP_MAX;
		if (idx == P_VAR) return (grp == GRP_BLACK) ? VAR_BLACK_MAX :
			(grp == GRP_BARS) ? VAR_BARS_MAX : 4'h0;
		if (idx == P_HDF) return HDF_MAX;
		if (idx >= P_AUX1 && idx < P_REF) return AUX_PULSE6;
		if (idx == P_REF) return REF_MAX;
		if (idx >= P_PRE1) return PRESET_MAX;
		return BIN_MAX;
	endfunction

	// First and last parameter of each panel section.
	function automatic logic [3:0] secFirst(input logic [1:0] sec);
		return (sec == 2'h0) ? P_GRP : (sec == 2'h1) ? P_STD : P_AUX1;
	endfunction

	function automatic logic [3:0] secLast(input logic [1:0] sec);
		return (sec == 2'h0) ? P_SLT : (sec == 2'h1) ? P_HDF : P_REF;
	endfunction

endpackage

// ---- hdl/fpc_sync.sv ----
// Three-stage pin synchroniser with agreement filter and rising-edge pulse.
`timescale 1ns/1ps
module fpc_sync #(
	parameter int W = 1
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic sampleEn,
	input wire logic [W-1:0] pinIn,
	output logic [W-1:0] lvl,
	output logic [W-1:0] rise
);

	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;

	// Shift the chain on each sample tick; slow ticks also reject bounce.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else if (sampleEn) begin
			s1_r <= pinIn;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// A bit changes only once stages two and three agree.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			lvl <= '0;
			rise <= '0;
		end else begin
			for (int i = 0; i < W; i++) begin
				rise[i] <= 1'b0;
				if (s2_r[i] == s3_r[i]) begin
					rise[i] <= s3_r[i] & ~lvl[i];
					lvl[i] <= s3_r[i];
				end
			end
		end
	end

endmodule

// ---- hdl/fpc_panel.sv ----
// Front-panel edit state machine, setting store, commit timer and lamp drive.
`timescale 1ns/1ps
module fpc_panel
	import fpc_pkg::*;
#(
	parameter int BLINK_CYCLES = BLINK_CYC,
	parameter int FLASH_CYCLES = FLASH_CYC,
	parameter int DEB_CYCLES = DEB_CYC
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [NBTN-1:0] btnPin,
	input wire logic [NSTS-1:0] stsPin,
	input wire logic hostWr,
	input wire fpc_wr_t hostReq,
	input wire logic loadWr,
	input wire fpc_wr_t loadReq,
	output logic nvWr,
	output fpc_wr_t nvReq,
	output logic [NGRP-1:0] patLamp,
	output logic audioLamp,
	output logic slateLamp,
	output logic [NHDF-1:0] hdLamp,
	output logic refLamp,
	output logic [1:0] stdLamp,
	output logic [1:0] modeLamp,
	output logic pwrLamp,
	output logic editOn,
	output logic valueOn,
	output logic [1:0] focusSec,
	output logic [3:0] focusSel,
	output fpc_pat_t sdiPattern,
	output fpc_pat_t cpstPattern,
	output logic cpstStd,
	output logic hdMode,
	output logic [1:0] hdFormat,
	output logic audioEmbed,
	output logic slateOn,
	output logic [NAUX-1:0][3:0] auxSel,
	output logic [1:0] refType
);

	localparam int BW = $clog2(BLINK_CYCLES + 1);
	localparam int FW = $clog2(FLASH_CYCLES + 1);
	localparam int DW = $clog2(DEB_CYCLES + 1);

	if (BLINK_CYCLES < 2 || FLASH_CYCLES < 2 || DEB_CYCLES < 1) begin : g_bad
		$error("fpc_panel: timing counts too small");
	end

	fpc_state_t state_r;
	logic [1:0] sec_r;
	logic [3:0] sel_r;
	logic [3:0] par_r [NPAR];
	logic [NPAR-1:0] dirty_r;
	logic [BW-1:0] blinkCnt_r;
	logic blinkRun_r;
	logic commit_r;
	logic nvHost_r;
	logic [FW-1:0] flashCnt_r;
	logic phase_r;
	logic [DW-1:0] debCnt_r;
	logic debTick;
	logic [NBTN-1:0] btnLvl;
	logic [NBTN-1:0] btnRise;
	logic [NSTS-1:0] stsLvl;
	logic modePress;
	logic rOnly;
	logic lOnly;
	logic bothArm;
	logic editEn;
	logic [3:0] editVal;
	logic [3:0] selMax;
	logic expire;
	logic commitGo;
	logic [3:0] cIdx;
	logic hostOk;
	logic loadOk;
	logic [NPAR-1:0] dirtySet;
	logic [NPAR-1:0] dirtyClr;

	// Lowest pending index, for the one-per-cycle commit walk.
	function automatic logic [3:0] lowestSet(input logic [NPAR-1:0] v);
		logic [3:0] r;
		r = 4'h0;
		for (int i = NPAR - 1; i >= 0; i--) begin
			if (v[i]) r = 4'(i);
		end
		return r;
	endfunction

	// Lamp on when its condition holds, gated by the flash phase while pending.
	function automatic logic lampOn(input logic on, input logic pend, input logic ph);
		return on & (~pend | ph);
	endfunction

	// Debounce sample tick for the buttons.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			debCnt_r <= '0;
			debTick <= 1'b0;
		end else begin
			debTick <= (debCnt_r == DW'(DEB_CYCLES - 1));
			debCnt_r <= (debCnt_r == DW'(DEB_CYCLES - 1)) ? '0 : debCnt_r + 1'b1;
		end
	end

	fpc_sync #(.W(NBTN)) u_btn (
		.mclk(mclk),
		.rst_b(rst_b),
		.sampleEn(debTick),
		.pinIn(btnPin),
		.lvl(btnLvl),
		.rise(btnRise)
	);

	fpc_sync #(.W(NSTS)) u_sts (
		.mclk(mclk),
		.rst_b(rst_b),
		.sampleEn(1'b1),
		.pinIn(stsPin),
		.lvl(stsLvl),
		.rise()
	);

	// Button decode: pressing both arrows toggles between stepping and value change.
	assign modePress = btnRise[BTN_MODE];
	assign rOnly = btnRise[BTN_RIGHT] & ~btnLvl[BTN_LEFT] & ~btnRise[BTN_LEFT];
	assign lOnly = btnRise[BTN_LEFT] & ~btnLvl[BTN_RIGHT] & ~btnRise[BTN_RIGHT];
	assign bothArm = (btnRise[BTN_RIGHT] & btnLvl[BTN_LEFT]) |
		(btnRise[BTN_LEFT] & btnLvl[BTN_RIGHT]);
	assign selMax = parMax(sel_r, par_r[P_GRP]);
	assign editEn = (state_r == ST_VALUE) & ~modePress & (rOnly | lOnly);
	assign editVal = rOnly ? ((par_r[sel_r] >= selMax) ? 4'h0 : par_r[sel_r] + 4'h1) :
		((par_r[sel_r] == 4'h0) ? selMax : par_r[sel_r] - 4'h1);
	assign hostOk = hostWr & (hostReq.idx < 4'(NPAR));
	assign loadOk = loadWr & (loadReq.idx < 4'(NPAR));

	// Edit focus: mode enters and tabs sections, arrows walk within one.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= ST_IDLE;
			sec_r <= 2'h0;
			sel_r <= P_GRP;
		end else if (modePress) begin
			if (state_r == ST_IDLE || sec_r == 2'(NSEC - 1)) begin
				state_r <= (state_r == ST_IDLE) ? ST_BROWSE : ST_IDLE;
				sec_r <= 2'h0;
				sel_r <= secFirst(2'h0);
			end else begin
				state_r <= ST_BROWSE;
				sec_r <= sec_r + 2'h1;
				sel_r <= secFirst(sec_r + 2'h1);
			end
		end else if (state_r != ST_IDLE && bothArm) begin
			state_r <= (state_r == ST_BROWSE) ? ST_VALUE : ST_BROWSE;
		end else if (state_r == ST_BROWSE && rOnly) begin
			sel_r <= (sel_r == secLast(sec_r)) ? secFirst(sec_r) : sel_r + 4'h1;
		end else if (state_r == ST_BROWSE && lOnly) begin
			sel_r <= (sel_r == secFirst(sec_r)) ? secLast(sec_r) : sel_r - 4'h1;
		end
	end

	// Setting store; presets are outside every section, so only the host and restore ports reach them.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < NPAR; i++) par_r[i] <= PAR_RST;
		end else begin
			for (int i = 0; i < NPAR; i++) begin
				if (hostOk && hostReq.idx == 4'(i)) begin
					par_r[i] <= (hostReq.val > parMax(4'(i), par_r[P_GRP])) ?
						parMax(4'(i), par_r[P_GRP]) : hostReq.val;
				end else if (loadOk && loadReq.idx == 4'(i)) begin
					par_r[i] <= (loadReq.val > parMax(4'(i), par_r[P_GRP])) ?
						parMax(4'(i), par_r[P_GRP]) : loadReq.val;
				end else if (editEn && sel_r == 4'(i)) begin
					par_r[i] <= editVal;
				end else if (4'(i) == P_VAR && editEn && sel_r == P_GRP) begin
					par_r[i] <= 4'h0;
				end
			end
		end
	end

	// Pending marks: a new edit wins over a clear in the same cycle.
	always_comb begin
		dirtySet = '0;
		dirtyClr = '0;
		if (editEn) dirtySet[sel_r] = 1'b1;
		if (hostOk) dirtyClr[hostReq.idx] = 1'b1;
		if (commitGo) dirtyClr[cIdx] = 1'b1;
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) dirty_r <= '0;
		else dirty_r <= (dirty_r & ~dirtyClr) | dirtySet;
	end

	// Blink timer, restarted by every edit.
	assign expire = blinkRun_r & (blinkCnt_r == '0);

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			blinkRun_r <= 1'b0;
			blinkCnt_r <= '0;
		end else if (editEn) begin
			blinkRun_r <= 1'b1;
			blinkCnt_r <= BW'(BLINK_CYCLES - 1);
		end else if (blinkRun_r) begin
			if (blinkCnt_r == '0) blinkRun_r <= 1'b0;
			else blinkCnt_r <= blinkCnt_r - 1'b1;
		end
	end

	// Commit walk starts only at expiry and stops on a fresh edit.
	assign cIdx = lowestSet(dirty_r);
	assign commitGo = commit_r & (|dirty_r) & ~hostOk & ~blinkRun_r;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) commit_r <= 1'b0;
		else if (editEn) commit_r <= 1'b0;
		else if (expire) commit_r <= 1'b1;
		else if (dirty_r == '0) commit_r <= 1'b0;
	end

	// Storage write port: host writes go straight through, panel edits at expiry.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			nvWr <= 1'b0;
			nvReq <= '0;
			nvHost_r <= 1'b0;
		end else begin
			nvWr <= hostOk | commitGo;
			nvHost_r <= hostOk;
			if (hostOk) begin
				nvReq.idx <= hostReq.idx;
				nvReq.val <= (hostReq.val > parMax(hostReq.idx, par_r[P_GRP])) ?
					parMax(hostReq.idx, par_r[P_GRP]) : hostReq.val;
			end else if (commitGo) begin
				nvReq.idx <= cIdx;
				nvReq.val <= par_r[cIdx];
			end
		end
	end

	// Flash divider: phase toggles every quarter second while anything is pending.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			flashCnt_r <= '0;
			phase_r <= 1'b1;
		end else if (dirty_r == '0) begin
			flashCnt_r <= '0;
			phase_r <= 1'b1;
		end else if (flashCnt_r == FW'(FLASH_CYCLES - 1)) begin
			flashCnt_r <= '0;
			phase_r <= ~phase_r;
		end else begin
			flashCnt_r <= flashCnt_r + 1'b1;
		end
	end

	// Lamp drive, one register per lamp.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			patLamp <= '0;
			hdLamp <= '0;
			audioLamp <= 1'b0;
			slateLamp <= 1'b0;
			stdLamp <= '0;
			modeLamp <= '0;
			refLamp <= 1'b0;
			pwrLamp <= 1'b0;
		end else begin
			for (int g = 0; g < NGRP; g++) begin
				patLamp[g] <= lampOn(par_r[P_GRP] == 4'(g),
					dirty_r[P_GRP] | dirty_r[P_VAR], phase_r);
			end
			for (int h = 0; h < NHDF; h++) begin
				hdLamp[h] <= lampOn(par_r[P_HDF] == 4'(h), dirty_r[P_HDF], phase_r);
			end
			audioLamp <= lampOn(par_r[P_AUD][0], dirty_r[P_AUD], phase_r);
			slateLamp <= lampOn(par_r[P_SLT][0], dirty_r[P_SLT], phase_r);
			stdLamp[0] <= lampOn(~par_r[P_STD][0], dirty_r[P_STD], phase_r);
			stdLamp[1] <= lampOn(par_r[P_STD][0], dirty_r[P_STD], phase_r);
			modeLamp[0] <= lampOn(~par_r[P_MOD][0], dirty_r[P_MOD], phase_r);
			modeLamp[1] <= lampOn(par_r[P_MOD][0], dirty_r[P_MOD], phase_r);
			refLamp <= stsLvl[STS_REFV] & stsLvl[STS_REFL];
			pwrLamp <= stsLvl[STS_PWR];
		end
	end

	// Settings and focus outputs, registered for the video and aux generators.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sdiPattern <= '0;
			cpstPattern <= '0;
			cpstStd <= 1'b0;
			hdMode <= 1'b0;
			hdFormat <= '0;
			audioEmbed <= 1'b0;
			slateOn <= 1'b0;
			auxSel <= '0;
			refType <= '0;
			editOn <= 1'b0;
			valueOn <= 1'b0;
			focusSec <= '0;
			focusSel <= '0;
		end else begin
			sdiPattern.grp <= par_r[P_GRP];
			sdiPattern.variant <= par_r[P_VAR];
			sdiPattern.preset <= (par_r[P_GRP] >= GRP_PRE1) ?
				par_r[P_PRE1 + par_r[P_GRP] - GRP_PRE1] : 4'h0;
			cpstPattern.grp <= par_r[P_GRP];
			cpstPattern.variant <= par_r[P_VAR];
			cpstPattern.preset <= (par_r[P_GRP] >= GRP_PRE1) ?
				par_r[P_PRE1 + par_r[P_GRP] - GRP_PRE1] : 4'h0;
			cpstStd <= par_r[P_STD][0];
			hdMode <= par_r[P_MOD][0];
			hdFormat <= par_r[P_HDF][1:0];
			audioEmbed <= par_r[P_AUD][0];
			slateOn <= par_r[P_SLT][0];
			for (int a = 0; a < NAUX; a++) auxSel[a] <= par_r[P_AUX1 + 4'(a)];
			refType <= par_r[P_REF][1:0];
			editOn <= (state_r != ST_IDLE);
			valueOn <= (state_r == ST_VALUE);
			focusSec <= sec_r;
			focusSel <= sel_r;
		end
	end

	// Checks on the edit flow, commit timing and lamp relations.
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	a_mode_enter: assert property (state_r == ST_IDLE && modePress |=>
		state_r == ST_BROWSE && sec_r == 2'h0) else $error("mode press did not enter edit");
	a_sec_step: assert property (state_r != ST_IDLE && modePress && sec_r != 2'h2 |=>
		sec_r == $past(sec_r) + 2'h1) else $error("mode press did not tab section");
	a_edit_mark: assert property (editEn |=> dirty_r[$past(sel_r)] &&
		par_r[$past(sel_r)] == $past(editVal)) else $error("edit not applied");
	a_commit_late: assert property (editEn ##1 (!editEn && !hostOk) [*8] |->
		!(nvWr && !nvHost_r)) else $error("storage written before timeout");
	a_commit_on: assert property (expire && !editEn && |dirty_r && !hostOk
		|=> ##1 nvWr) else $error("no storage write after timeout");
	a_pat_one: assert property ($past(rst_b) && !dirty_r[P_GRP] && !dirty_r[P_VAR] &&
		$past(!dirty_r[P_GRP] && !dirty_r[P_VAR]) |-> $onehot(patLamp))
		else $error("pattern lamps not one-hot");
	a_ref_lamp: assert property (refLamp |->
		$past(stsLvl[STS_REFV]) && $past(stsLvl[STS_REFL])) else $error("ref lamp wrong");
	a_pwr_lamp: assert property ($rose(stsLvl[STS_PWR]) |=> pwrLamp)
		else $error("power lamp late");
	a_audio_lamp: assert property (!dirty_r[P_AUD] ##1 !dirty_r[P_AUD] |->
		audioLamp == $past(par_r[P_AUD][0])) else $error("audio lamp wrong");
	a_flash_rate: assert property ($changed(phase_r) && |dirty_r && $past(|dirty_r) |->
		$past(flashCnt_r) == FW'(FLASH_CYCLES - 1)) else $error("flash rate wrong");
	a_cpst_same: assert property (cpstPattern == sdiPattern)
		else $error("composite pattern differs");

	c_enter_edit: cover property (state_r == ST_IDLE ##1 state_r == ST_BROWSE);
	c_value_edit: cover property (editEn);
	c_commit: cover property (nvWr && !nvHost_r);
	c_host_write: cover property (nvWr && nvHost_r);

endmodule

// ---- verif/fpc_operator.sv ----
// Operator model that presses the panel buttons as a person would.
`timescale 1ns/1ps
module fpc_operator
	import fpc_pkg::*;
#(
	parameter int HOLD = 16
) (
	input wire logic mclk,
	output logic [NBTN-1:0] btnPin
);
	// Released buttons read low, so the idle pins sit at zero.
	initial begin
		btnPin = '0;
	end

	// Holds the chosen buttons long enough for the slow sampler, then lets go.
	task automatic press(input logic [NBTN-1:0] mask);
		@(posedge mclk);
		#1;
		btnPin = mask;
		repeat (HOLD) @(posedge mclk);
		#1;
		btnPin = '0;
		repeat (HOLD) @(posedge mclk);
		#1;
	endtask
endmodule

// ---- verif/front_panel_control_tb.sv ----
// Self-checking bench for the front-panel control block.
`timescale 1ns/1ps
module front_panel_control_tb;
	import fpc_pkg::*;
	localparam int BLK = 200;
	localparam int HOLD = 16;
	localparam logic [2:0] B_MODE = 3'h1;
	localparam logic [2:0] B_RIGHT = 3'h2;
	localparam logic [2:0] B_LEFT = 3'h4;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic [NBTN-1:0] btnPin;
	logic [NSTS-1:0] stsPin = '0;
	logic hostWr = 1'b0;
	logic loadWr = 1'b0;
	fpc_wr_t hostReq = '0;
	fpc_wr_t loadReq = '0;
	fpc_wr_t nvReq;
	fpc_wr_t nvLast = '0;
	fpc_pat_t sdiPattern, cpstPattern;
	logic nvWr, audioLamp, slateLamp, refLamp, pwrLamp, editOn, valueOn;
	logic cpstStd, hdMode, audioEmbed, slateOn;
	logic [NGRP-1:0] patLamp;
	logic [NHDF-1:0] hdLamp;
	logic [1:0] stdLamp, modeLamp, focusSec, hdFormat, refType;
	logic [3:0] focusSel;
	logic [NAUX-1:0][3:0] auxSel;
	int n_errors = 0;
	int n_compared = 0;
	int nvCount = 0;
	int n0, w, tog;
	logic lastLamp;
	logic [3:0] preExp;

	fpc_panel #(.BLINK_CYCLES(BLK), .FLASH_CYCLES(10), .DEB_CYCLES(2)) fpc_panel_inst (
		.mclk(mclk), .rst_b(rst_b), .btnPin(btnPin), .stsPin(stsPin),
		.hostWr(hostWr), .hostReq(hostReq), .loadWr(loadWr), .loadReq(loadReq),
		.nvWr(nvWr), .nvReq(nvReq), .patLamp(patLamp), .audioLamp(audioLamp),
		.slateLamp(slateLamp), .hdLamp(hdLamp), .refLamp(refLamp), .stdLamp(stdLamp),
		.modeLamp(modeLamp), .pwrLamp(pwrLamp), .editOn(editOn), .valueOn(valueOn),
		.focusSec(focusSec), .focusSel(focusSel), .sdiPattern(sdiPattern),
		.cpstPattern(cpstPattern), .cpstStd(cpstStd), .hdMode(hdMode),
		.hdFormat(hdFormat), .audioEmbed(audioEmbed), .slateOn(slateOn),
		.auxSel(auxSel), .refType(refType)
	);

	fpc_operator #(.HOLD(HOLD)) fpc_operator_inst (.mclk(mclk), .btnPin(btnPin));

	// The clock runs at 10 MHz.
	always #50 mclk = ~mclk;

	// Every storage write is counted and the latest word written is kept.
	always @(posedge mclk) begin
		if (nvWr === 1'b1) begin
			nvCount++;
			nvLast = nvReq;
		end
	end

	task automatic summarize();
		if (n_errors == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic do_reset();
		rst_b = 1'b0;
		repeat (20) @(posedge mclk);
		#1;
		rst_b = 1'b1;
		repeat (3) @(posedge mclk);
		#1;
	endtask

	// One-cycle write strobe on the host port or the restore port.
	task automatic hw(input logic [3:0] idx, input logic [3:0] val, input logic ld);
		@(posedge mclk);
		#1;
		hostWr = ~ld;
		loadWr = ld;
		hostReq = {idx, val};
		loadReq = {idx, val};
		@(posedge mclk);
		#1;
		hostWr = 1'b0;
		loadWr = 1'b0;
		repeat (3) @(posedge mclk);
		#1;
	endtask

	// Host write that must be stored at once with the clipped value.
	task automatic hwc(input logic [3:0] idx, input logic [3:0] val, input logic [3:0] expv);
		int c;
		c = nvCount;
		hw(idx, val, 1'b0);
		check("nvWr count", nvCount - c, 1);
		check("nvReq", nvLast, {idx, expv});
	endtask

	// Main sequence: host settings first, then panel browsing and editing.
	initial begin
		do_reset();
		check("patLamp rst", patLamp, 7'h01);
		check("hdLamp rst", hdLamp, 4'h1);
		check("stdLamp rst", stdLamp, 2'h1);
		check("modeLamp rst", modeLamp, 2'h1);
		for (int i = 0; i < 8; i++) begin
			stsPin = i[2:0];
			repeat (6) @(posedge mclk);
			#1;
			check("pwrLamp", pwrLamp, i[0]);
			check("refLamp", refLamp, i[1] & i[2]);
		end
		hwc(P_AUD, 4'h1, 4'h1);
		check("audioLamp on", {audioLamp, audioEmbed}, 2'h3);
		hwc(P_AUD, 4'h0, 4'h0);
		check("audioLamp off", audioLamp, 1'b0);
		hwc(P_SLT, 4'h1, 4'h1);
		check("slateLamp", {slateLamp, slateOn}, 2'h3);
		n0 = nvCount;
		hw(P_SLT, 4'h0, 1'b1);
		check("load slate", {slateLamp, slateOn}, 2'h0);
		check("load no store", nvCount - n0, 0);
		for (int f = 0; f < 4; f++) begin
			hwc(P_HDF, f[3:0], f[3:0]);
			check("hdLamp", hdLamp, 4'h1 << f);
			check("hdFormat", hdFormat, f[1:0]);
		end
		hwc(P_STD, 4'h1, 4'h1);
		check("stdLamp", {stdLamp, cpstStd}, 3'h5);
		hwc(P_MOD, 4'h1, 4'h1);
		check("modeLamp", {modeLamp, hdMode}, 3'h5);
		hwc(P_AUX1, 4'hF, AUX_PULSE6);
		hwc(P_AUX1 + 4'h1, AUX_LTC, AUX_LTC);
		hwc(P_AUX1 + 4'h2, AUX_SILENCE, AUX_SILENCE);
		check("auxSel", auxSel, {AUX_SILENCE, AUX_LTC, AUX_PULSE6});
		for (int r = 0; r < 4; r++) begin
			hwc(P_REF, r[3:0], r[3:0]);
			check("refType", refType, r[1:0]);
		end
		hwc(P_PRE1 + 4'h2, 4'hF, PRESET_MAX);
		hwc(P_PRE1, 4'h7, 4'h7);
		for (int g = 0; g < 7; g++) begin
			hwc(P_GRP, g[3:0], g[3:0]);
			check("patLamp", patLamp, 7'h01 << g);
			preExp = (g == 4) ? 4'h7 : (g == 6) ? PRESET_MAX : 4'h0;
			check("cpst pattern", cpstPattern, {g[3:0], 4'h0, preExp});
			check("sdi pattern", sdiPattern, {g[3:0], 4'h0, preExp});
			if (g == 4 || g == 6) begin
				check("preset", sdiPattern.preset, (g == 4) ? 4'h7 : PRESET_MAX);
			end
		end
		hwc(P_VAR, 4'h3, 4'h0);
		hwc(P_GRP, GRP_BARS, GRP_BARS);
		hwc(P_VAR, 4'hF, VAR_BARS_MAX);
		check("bars variant", {patLamp, sdiPattern.variant}, {7'h02, VAR_BARS_MAX});
		n0 = nvCount;
		hw(4'hE, 4'h1, 1'b0);
		check("host refused", nvCount - n0, 0);
		do_reset();
		fpc_operator_inst.press(B_MODE);
		check("edit entry", {editOn, focusSec, focusSel}, 7'h40);
		for (int i = 1; i <= 4; i++) begin
			fpc_operator_inst.press(B_RIGHT);
			check("focusSel", focusSel, i % 4);
		end
		fpc_operator_inst.press(B_MODE);
		check("focusSec 1", focusSec, 2'h1);
		fpc_operator_inst.press(B_MODE);
		check("focusSec 2", focusSec, 2'h2);
		for (int i = 0; i < 5; i++) begin
			fpc_operator_inst.press(B_RIGHT);
			check("host only", focusSel >= 4'h7 && focusSel <= 4'hA, 1'b1);
		end
		fpc_operator_inst.press(B_MODE);
		check("edit exit", editOn, 1'b0);
		fpc_operator_inst.press(B_RIGHT);
		check("idle arrow", {editOn, patLamp}, 8'h01);
		fpc_operator_inst.press(B_MODE);
		fpc_operator_inst.press(B_RIGHT | B_LEFT);
		check("valueOn", valueOn, 1'b1);
		n0 = nvCount;
		fpc_operator_inst.press(B_LEFT);
		check("grp wrap down", {sdiPattern.grp, sdiPattern.variant}, 8'h60);
		check("grp wrap lamps", patLamp & 7'h3F, 7'h00);
		fpc_operator_inst.press(B_RIGHT);
		fpc_operator_inst.press(B_RIGHT);
		check("no early store", nvCount - n0, 0);
		tog = 0;
		lastLamp = patLamp[1];
		for (int i = 0; i < 40; i++) begin
			@(posedge mclk);
			#1;
			check("other lamps dark", patLamp & 7'h7D, 7'h00);
			tog += (patLamp[1] !== lastLamp);
			lastLamp = patLamp[1];
		end
		check("blinking", tog >= 2, 1'b1);
		check("still pending", nvCount - n0, 0);
		w = 0;
		while (nvCount == n0 && w < 400) begin
			@(posedge mclk);
			#1;
			w++;
		end
		// A commit that never arrives counts as a mismatch of its own.
		if (nvCount == n0) n_errors++;
		check("commit word", nvLast, {P_GRP, 4'h1});
		check("commit time", (w + 2 * HOLD + 40) inside {[BLK:BLK + 20]}, 1'b1);
		repeat (20) @(posedge mclk);
		for (int i = 0; i < 20; i++) begin
			@(posedge mclk);
			#1;
			check("steady lamp", patLamp, 7'h02);
		end
		fpc_operator_inst.press(B_RIGHT);
		repeat (30) @(posedge mclk);
		do_reset();
		n0 = nvCount;
		repeat (300) @(posedge mclk);
		#1;
		check("lost edit", nvCount - n0, 0);
		check("lost value", patLamp, 7'h01);
		summarize();
	end

	// A run that overstays its budget counts as a failure.
	initial begin
		repeat (60000) @(posedge mclk);
		n_errors++;
		summarize();
	end
endmodule
